// File: design/swa_attr_bank.sv
/*
 * Attribute bank of two switching I/O instances (7 and 8) and the
 * activation object, served by single-attribute get/set requests.
 * Assumes one request per strobe pulse from a same-clock protocol stack,
 * switching pin levels asynchronous, result store on same clock.
 */
`timescale 1ns/100ps
`include "swa_defines.svh"

module swa_attr_bank (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// attribute request
	input wire logic i_req,
	input wire logic [7:0] i_service,
	input wire logic [7:0] i_class,
	input wire logic [7:0] i_instance,
	input wire logic [7:0] i_attribute,
	input wire logic [7:0] i_wdata,
	// attribute answer
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_status,
	output logic [7:0] o_rsp_data,
	// switching pins
	input wire logic [1:0] i_switch_pin,
	output logic [1:0] o_switched_output_line,
	// comparison configuration
	input wire logic [15:0] i_cmp_value_io7,
	input wire logic [15:0] i_cmp_value_io8,
	input wire logic [1:0] i_multi_mode,
	// result store side
	input wire logic i_result_ready,
	input wire logic [7:0] i_buffered_count,
	output logic o_result_take,
	output logic o_result_discard,
	output logic o_input_area_clear,
	output logic o_acquire,
	output logic o_acquire_start,
	output logic o_acquire_stop,
	output logic o_waiting_ack
);
	typedef struct packed {
		logic [1:0] pin_meta;
		logic [1:0] pin_sync;
		logic [7:0] mode;
		logic [7:0] act_prev;
		logic [7:0] ack_prev;
		logic [7:0] reset_prev;
		logic acquire;
		logic start_pulse;
		logic stop_pulse;
		logic take_pulse;
		logic discard_pulse;
		logic clear_pulse;
		swa_pkg::swa_hs_t hs;
		logic rsp_valid;
		logic [7:0] rsp_status;
		logic [7:0] rsp_data;
	} swa_bank_t;

	swa_bank_t st;
	swa_bank_t next_st;
	logic [1:0] wr_drive;
	logic [1:0] wr_clear;
	logic [7:0] drive [2];
	logic [1:0] cmp_state;
	logic [1:0] cmp_toggle;
	logic [15:0] cmp_value [2];
	logic [1:0] io_sel;
	logic act_sel;
	logic is_get;
	logic is_set;
	logic ack_edge;
	logic act_rise;
	logic act_fall;
	logic reset_rise;
	logic [7:0] attr;

	assign is_get = i_req && i_service == `SWA_SVC_GET;
	assign is_set = i_req && i_service == `SWA_SVC_SET;
	assign attr = i_attribute;
	assign io_sel[0] = i_class == `SWA_CLASS_SWITCH_IO && i_instance == `SWA_INST_IO7;
	assign io_sel[1] = i_class == `SWA_CLASS_SWITCH_IO && i_instance == `SWA_INST_IO8;
	assign act_sel = i_class == `SWA_CLASS_ACT && i_instance == `SWA_INST_ACT;
	assign cmp_value[0] = i_cmp_value_io7;
	assign cmp_value[1] = i_cmp_value_io8;

	assign act_rise = is_set && act_sel && attr == `SWA_ATTR_ACTIVATE && i_wdata[0] && !st.act_prev[0];
	assign act_fall = is_set && act_sel && attr == `SWA_ATTR_ACTIVATE && !i_wdata[0] && st.act_prev[0];
	assign ack_edge = is_set && act_sel && attr == `SWA_ATTR_ACK && (i_wdata[0] != st.ack_prev[0]);
	assign reset_rise = is_set && act_sel && attr == `SWA_ATTR_DATA_RESET && i_wdata[0] && !st.reset_prev[0];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_io
			assign wr_drive[g] = is_set && io_sel[g] && attr == `SWA_ATTR_OUT_DRIVE && i_wdata <= `SWA_FLAG_MAX;
			assign wr_clear[g] = is_set && io_sel[g] && attr == `SWA_ATTR_CNT_CLEAR && i_wdata <= `SWA_FLAG_MAX;
			swa_switch_io u_io (
				.i_mclk(i_mclk),
				.i_reset_n(i_reset_n),
				.i_wr_drive(wr_drive[g]),
				.i_wr_clear(wr_clear[g]),
				.i_wdata(i_wdata),
				.i_cmp_value(cmp_value[g]),
				.i_multi_mode(i_multi_mode[g]),
				.i_sig_level(st.pin_sync[g]),
				.o_drive(drive[g]),
				.o_cmp_state(cmp_state[g]),
				.o_cmp_toggle(cmp_toggle[g]),
				.o_count()
			);
			// 0 low inactive, 1 high active
			assign o_switched_output_line[g] = drive[g][0];
		end
	endgenerate

	always_comb begin
		next_st = st;
		next_st.pin_meta = i_switch_pin;
		next_st.pin_sync = st.pin_meta;
		next_st.start_pulse = 1'b0;
		next_st.stop_pulse = 1'b0;
		next_st.take_pulse = 1'b0;
		next_st.discard_pulse = 1'b0;
		next_st.clear_pulse = 1'b0;
		next_st.rsp_valid = i_req;
		next_st.rsp_status = `SWA_ERR_OK;
		next_st.rsp_data = 8'h00;

		// request decode
		if (i_req) begin
			if (!is_get && !is_set) begin
				next_st.rsp_status = `SWA_ERR_BAD_SVC;
			end else if (io_sel != 2'b00) begin
				if (attr <= `SWA_ATTR_RSV_MAX || attr > `SWA_ATTR_CMP_TOGGLE) begin
					next_st.rsp_status = `SWA_ERR_BAD_ATTR;
				end else if (is_get) begin
					unique case (attr)
						`SWA_ATTR_SIG_STATE: next_st.rsp_data = {7'h00, st.pin_sync[io_sel[1]]};
						`SWA_ATTR_CMP_STATE: next_st.rsp_data = {7'h00, cmp_state[io_sel[1]]};
						`SWA_ATTR_CMP_TOGGLE: next_st.rsp_data = {7'h00, cmp_toggle[io_sel[1]]};
						default: next_st.rsp_status = `SWA_ERR_BAD_ATTR;
					endcase
				end else if (attr != `SWA_ATTR_OUT_DRIVE && attr != `SWA_ATTR_CNT_CLEAR) begin
					next_st.rsp_status = `SWA_ERR_NOT_SETTABLE;
				end else if (i_wdata > `SWA_FLAG_MAX) begin
					next_st.rsp_status = `SWA_ERR_BAD_VALUE;
				end
			end else if (act_sel) begin
				if (attr < `SWA_ATTR_MODE || attr > `SWA_ATTR_DATA_RESET) begin
					next_st.rsp_status = `SWA_ERR_BAD_ATTR;
				end else if (is_get) begin
					if (attr == `SWA_ATTR_NUM_RESULTS) begin
						next_st.rsp_data = i_buffered_count;
					end else begin
						next_st.rsp_status = `SWA_ERR_BAD_ATTR;
					end
				end else if (attr == `SWA_ATTR_NUM_RESULTS) begin
					next_st.rsp_status = `SWA_ERR_NOT_SETTABLE;
				end else if (attr == `SWA_ATTR_MODE) begin
					if (i_wdata < `SWA_MODE_MIN || i_wdata > `SWA_MODE_MAX) begin
						next_st.rsp_status = `SWA_ERR_BAD_VALUE;
					end else begin
						next_st.mode = i_wdata;
					end
				end else if (i_wdata > `SWA_FLAG_MAX) begin
					next_st.rsp_status = `SWA_ERR_BAD_VALUE;
				end else begin
					unique case (attr)
						`SWA_ATTR_ACTIVATE: next_st.act_prev = i_wdata;
						`SWA_ATTR_ACK: next_st.ack_prev = i_wdata;
						default: next_st.reset_prev = i_wdata;
					endcase
				end
			end else begin
				next_st.rsp_status = `SWA_ERR_NO_OBJECT;
			end
		end

		if (act_rise) begin
			next_st.acquire = 1'b1;
			next_st.start_pulse = 1'b1;
		end else if (act_fall) begin
			next_st.acquire = 1'b0;
			next_st.stop_pulse = 1'b1;
		end

		if (reset_rise) begin
			next_st.discard_pulse = 1'b1;
			next_st.clear_pulse = 1'b1;
			next_st.hs = swa_pkg::SWA_IDLE;
		end else begin
			unique case (st.hs)
				swa_pkg::SWA_IDLE: begin
					if (i_result_ready) begin
						next_st.take_pulse = 1'b1;
						next_st.hs = swa_pkg::SWA_WAIT_ACK;
					end
				end
				swa_pkg::SWA_WAIT_ACK: begin
					if (ack_edge) begin
						next_st.hs = i_result_ready ? swa_pkg::SWA_IDLE : swa_pkg::SWA_CLEAR;
					end
				end
				swa_pkg::SWA_CLEAR: begin
					next_st.clear_pulse = 1'b1;
					next_st.hs = swa_pkg::SWA_IDLE;
				end
				default: next_st.hs = swa_pkg::SWA_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			st <= '0;
			st.mode <= `SWA_MODE_RESET;
			st.hs <= swa_pkg::SWA_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign o_rsp_valid = st.rsp_valid;
	assign o_rsp_status = st.rsp_status;
	assign o_rsp_data = st.rsp_data;
	assign o_result_take = st.take_pulse;
	assign o_result_discard = st.discard_pulse;
	assign o_input_area_clear = st.clear_pulse;
	assign o_acquire = st.acquire;
	assign o_acquire_start = st.start_pulse;
	assign o_acquire_stop = st.stop_pulse;
	assign o_waiting_ack = st.hs == swa_pkg::SWA_WAIT_ACK;
endmodule

// File: design/swa_switch_io.sv
/*
 * One switching input/output instance: drive level, event counter with
 * clear on rising change of the clear attribute, comparison flags.
 * Assumes i_sig_level is already synchronised to i_mclk.
 */
`timescale 1ns/100ps
`include "swa_defines.svh"

module swa_switch_io (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// attribute writes
	input wire logic i_wr_drive,
	input wire logic i_wr_clear,
	input wire logic [7:0] i_wdata,
	// configuration
	input wire logic [15:0] i_cmp_value,
	input wire logic i_multi_mode,
	// activation events and level
	input wire logic i_sig_level,
	// state
	output logic [7:0] o_drive,
	output logic o_cmp_state,
	output logic o_cmp_toggle,
	output logic [15:0] o_count
);
	swa_pkg::swa_io_t st;
	swa_pkg::swa_io_t next_st;
	logic sig_prev;
	logic sig_rise;
	logic clear_rise;
	logic over_now;

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			sig_prev <= 1'b0;
		end else begin
			sig_prev <= i_sig_level;
		end
	end

	assign sig_rise = i_sig_level && !sig_prev;
	assign clear_rise = i_wr_clear && i_wdata[0] && !st.clear_prev[0];

	always_comb begin
		next_st = st;
		next_st.cmp_value = i_cmp_value;
		next_st.multi_mode = i_multi_mode;
		over_now = 1'b0;
		if (i_wr_drive) begin
			next_st.drive = i_wdata;
		end
		if (i_wr_clear) begin
			next_st.clear_prev = i_wdata;
		end
		if (clear_rise) begin
			next_st.count = 16'h0000;
			next_st.cmp_state = 1'b0;
			next_st.cmp_toggle = 1'b0;
		end else if (sig_rise && st.count != 16'hFFFF) begin
			next_st.count = st.count + 16'h0001;
			over_now = (st.count + 16'h0001) > st.cmp_value;
			if (over_now) begin
				next_st.cmp_state = 1'b1;
			end
			if (over_now && st.multi_mode) begin
				next_st.cmp_toggle = !st.cmp_toggle;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_drive = st.drive;
	assign o_cmp_state = st.cmp_state;
	assign o_cmp_toggle = st.cmp_toggle;
	assign o_count = st.count;
endmodule

// File: include/swa_defines.svh
/*
 * Object and attribute codes, reset values and limits of the switching
 * I/O and activation attribute bank. Included by the design files.
 */
`ifndef SWA_DEFINES_SVH
`define SWA_DEFINES_SVH

`define SWA_CLASS_SWITCH_IO 8'h67
`define SWA_CLASS_ACT 8'h6A
`define SWA_SVC_GET 8'h0E
`define SWA_SVC_SET 8'h10
`define SWA_INST_IO7 8'h07
`define SWA_INST_IO8 8'h08
`define SWA_INST_ACT 8'h01
`define SWA_ATTR_SIG_STATE 8'h05
`define SWA_ATTR_OUT_DRIVE 8'h06
`define SWA_ATTR_CNT_CLEAR 8'h07
`define SWA_ATTR_CMP_STATE 8'h08
`define SWA_ATTR_CMP_TOGGLE 8'h09
`define SWA_ATTR_RSV_MAX 8'h04
`define SWA_ATTR_MODE 8'h01
`define SWA_ATTR_NUM_RESULTS 8'h02
`define SWA_ATTR_ACTIVATE 8'h03
`define SWA_ATTR_ACK 8'h04
`define SWA_ATTR_DATA_RESET 8'h05
`define SWA_MODE_RESET 8'h01
`define SWA_MODE_MIN 8'h01
`define SWA_MODE_MAX 8'h01
`define SWA_FLAG_MAX 8'h01
`define SWA_ERR_OK 8'h00
`define SWA_ERR_BAD_SVC 8'h08
`define SWA_ERR_BAD_ATTR 8'h14
`define SWA_ERR_BAD_VALUE 8'h09
`define SWA_ERR_NOT_SETTABLE 8'h0E
`define SWA_ERR_NO_OBJECT 8'h16

`endif

// File: include/swa_pkg.sv
/*
 * Types of the switching I/O and activation attribute bank.
 * Assumes swa_defines.svh is on the include path.
 */
package swa_pkg;
	typedef enum logic [1:0] {
		SWA_IDLE = 2'b00,
		SWA_WAIT_ACK = 2'b01,
		SWA_CLEAR = 2'b11
	} swa_hs_t;

	typedef struct packed {
		logic [7:0] drive;
		logic [7:0] clear_prev;
		logic [15:0] count;
		logic [15:0] cmp_value;
		logic cmp_state;
		logic cmp_toggle;
		logic multi_mode;
	} swa_io_t;
endpackage

// File: test/swa_attr_bank_tb_top.sv
/* bench of swa_attr_bank with the store model; inputs change at falling edge */
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module swa_attr_bank_tb_top;
	localparam logic [7:0] rd = 8'h0E;
	localparam logic [7:0] wr = 8'h10;
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_req = 1'b0;
	logic [7:0] i_service = 8'h00, i_class = 8'h00, i_instance = 8'h00, i_attribute = 8'h00, i_wdata = 8'h00;
	logic [1:0] i_switch_pin = 2'b00;
	logic [7:0] o_rsp_status, o_rsp_data, cnt;
	logic [1:0] o_switched_output_line;
	logic o_rsp_valid, o_result_take, o_result_discard, o_input_area_clear, o_acquire, o_waiting_ack, rdy;
	int errors = 0, num_checks = 0, cycles = 0, clears = 0;
	swa_store_model u_store (.i_mclk, .i_take(o_result_take), .i_discard(o_result_discard), .o_ready(rdy),
		.o_count(cnt));
	swa_attr_bank u_dut (.i_mclk, .i_reset_n, .i_req, .i_service, .i_class, .i_instance, .i_attribute, .i_wdata,
		.o_rsp_valid, .o_rsp_status, .o_rsp_data, .i_switch_pin, .o_switched_output_line,
		.i_cmp_value_io7(16'h0001), .i_cmp_value_io8(16'h0001), .i_multi_mode(2'b01), .i_result_ready(rdy),
		.i_buffered_count(cnt), .o_result_take, .o_result_discard, .o_input_area_clear, .o_acquire,
		.o_acquire_start(), .o_acquire_stop(), .o_waiting_ack);
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] svc, cls, inst, attr, wd, st, dat);
		@(negedge i_mclk);
		{i_req, i_service, i_class, i_instance, i_attribute, i_wdata} = {1'b1, svc, cls, inst, attr, wd};
		@(negedge i_mclk);
		i_req = 1'b0;
		`CHK(o_rsp_valid, 1'b1)
		`CHK(o_rsp_status, st)
		`CHK(o_rsp_data, dat)
	endtask
	task automatic io(input logic [7:0] svc, inst, attr, wd, st, dat);
		xfer(svc, 8'h67, inst, attr, wd, st, dat);
	endtask
	task automatic ac(input logic [7:0] svc, attr, wd, st, dat);
		xfer(svc, 8'h6A, 8'h01, attr, wd, st, dat);
	endtask
	task automatic pulse();
		i_switch_pin[0] = 1'b1;
		repeat (4) @(negedge i_mclk);
		i_switch_pin[0] = 1'b0;
		repeat (4) @(negedge i_mclk);
	endtask
	initial begin
		forever #12.5 i_mclk = ~i_mclk;
	end
	// sample registered pulses away from the launching edge
	always @(negedge i_mclk) begin
		cycles++;
		if (o_input_area_clear)
			clears++;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(negedge i_mclk);
		i_reset_n = 1'b1;
		io(rd, 8'h07, 8'h05, 8'h00, 8'h00, 8'h00);
		for (int a = 1; a < 5; a++) begin
			io(rd, 8'h07, a[7:0], 8'h00, 8'h14, 8'h00);
			io(wr, 8'h08, a[7:0], 8'h01, 8'h14, 8'h00);
		end
		xfer(8'h01, 8'h6A, 8'h01, 8'h02, 8'h00, 8'h08, 8'h00);
		xfer(rd, 8'h6B, 8'h01, 8'h02, 8'h00, 8'h16, 8'h00);
		io(wr, 8'h07, 8'h06, 8'h01, 8'h00, 8'h00);
		io(wr, 8'h08, 8'h06, 8'h01, 8'h00, 8'h00);
		`CHK(o_switched_output_line, 2'b11)
		io(wr, 8'h07, 8'h06, 8'h00, 8'h00, 8'h00);
		`CHK(o_switched_output_line, 2'b10)
		i_switch_pin = 2'b10;
		repeat (4) @(negedge i_mclk);
		io(rd, 8'h08, 8'h05, 8'h00, 8'h00, 8'h01);
		i_switch_pin = 2'b00;
		for (int n = 1; n < 4; n++) begin
			pulse();
			io(rd, 8'h07, 8'h08, 8'h00, 8'h00, {7'h00, n > 1});
			io(rd, 8'h07, 8'h09, 8'h00, 8'h00, {7'h00, n == 2});
		end
		io(wr, 8'h07, 8'h07, 8'h01, 8'h00, 8'h00);
		io(rd, 8'h07, 8'h08, 8'h00, 8'h00, 8'h00);
		io(rd, 8'h07, 8'h09, 8'h00, 8'h00, 8'h00);
		pulse();
		pulse();
		io(wr, 8'h07, 8'h07, 8'h00, 8'h00, 8'h00);
		io(rd, 8'h07, 8'h08, 8'h00, 8'h00, 8'h01);
		ac(wr, 8'h01, 8'h02, 8'h09, 8'h00);
		ac(wr, 8'h01, 8'h01, 8'h00, 8'h00);
		ac(wr, 8'h03, 8'h01, 8'h00, 8'h00);
		@(negedge i_mclk);
		`CHK(o_acquire, 1'b1)
		ac(wr, 8'h03, 8'h00, 8'h00, 8'h00);
		@(negedge i_mclk);
		`CHK(o_acquire, 1'b0)
		u_store.pend = 8'h02;
		repeat (3) @(negedge i_mclk);
		`CHK(o_waiting_ack, 1'b1)
		ac(rd, 8'h02, 8'h00, 8'h00, 8'h01);
		`CHK(cnt, 8'h01)
		ac(wr, 8'h04, 8'h01, 8'h00, 8'h00);
		repeat (4) @(negedge i_mclk);
		`CHK(cnt, 8'h00)
		`CHK(clears, 0)
		ac(wr, 8'h04, 8'h00, 8'h00, 8'h00);
		repeat (3) @(negedge i_mclk);
		`CHK(o_waiting_ack, 1'b0)
		`CHK(clears, 1)
		u_store.pend = 8'h03;
		repeat (3) @(negedge i_mclk);
		ac(wr, 8'h05, 8'h01, 8'h00, 8'h00);
		repeat (3) @(negedge i_mclk);
		`CHK(cnt, 8'h00)
		`CHK(clears, 2)
		`CHK(o_waiting_ack, 1'b0)
		give_verdict();
	end
endmodule

// File: test/swa_bank_monitor.sv
/* port checker of swa_attr_bank; bound to it, one clock, sync reset */
`timescale 1ns/100ps
module swa_bank_monitor (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// request
	input wire logic i_req,
	input wire logic [7:0] i_service,
	input wire logic [7:0] i_class,
	input wire logic [7:0] i_instance,
	input wire logic [7:0] i_attribute,
	input wire logic [7:0] i_wdata,
	// answer and state
	input wire logic o_rsp_valid,
	input wire logic [7:0] o_rsp_status,
	input wire logic [1:0] o_switched_output_line,
	input wire logic o_result_take,
	input wire logic o_result_discard,
	input wire logic o_input_area_clear,
	input wire logic o_acquire,
	input wire logic o_acquire_start,
	input wire logic o_waiting_ack
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	wire wr = i_req && i_service == 8'h10;
	wire act = i_class == 8'h6A && i_instance == 8'h01;
	wire io7 = i_req && i_class == 8'h67 && i_instance == 8'h07;
	property p_lat;
		i_req |=> o_rsp_valid;
	endproperty
	a_lat: assert property (p_lat) else $error("answer missing");
	property p_quiet;
		!i_req |=> !o_rsp_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("answer unasked");
	property p_drive;
		wr && io7 && i_attribute == 8'h06 && i_wdata < 8'h02 |=> o_switched_output_line[0] == $past(i_wdata[0]);
	endproperty
	a_drive: assert property (p_drive) else $error("drive level wrong");
	property p_rsv;
		io7 && i_attribute > 8'h00 && i_attribute < 8'h05 |=> o_rsp_status == 8'h14;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved accepted");
	property p_mode;
		wr && act && i_attribute == 8'h01 && i_wdata != 8'h01 |=> o_rsp_status == 8'h09;
	endproperty
	a_mode: assert property (p_mode) else $error("mode accepted");
	property p_hold;
		o_waiting_ack && $past(o_waiting_ack) |-> !o_result_take;
	endproperty
	a_hold: assert property (p_hold) else $error("result before ack");
	property p_discard;
		o_result_discard |-> o_input_area_clear;
	endproperty
	a_discard: assert property (p_discard) else $error("area kept");
	property p_start;
		o_acquire_start |-> o_acquire;
	endproperty
	a_start: assert property (p_start) else $error("start without acquire");
endmodule
bind swa_attr_bank swa_bank_monitor u_mon (.i_mclk, .i_reset_n, .i_req, .i_service, .i_class, .i_instance,
	.i_attribute, .i_wdata, .o_rsp_valid, .o_rsp_status, .o_switched_output_line, .o_result_take,
	.o_result_discard, .o_input_area_clear, .o_acquire, .o_acquire_start, .o_waiting_ack);

// File: test/swa_store_model.sv
/* result store on the far side of the bank; same clock, no reset */
`timescale 1ns/100ps
module swa_store_model (
	// clock
	input wire logic i_mclk,
	// bank controls
	input wire logic i_take,
	input wire logic i_discard,
	// store state
	output logic o_ready,
	output logic [7:0] o_count
);
	logic [7:0] pend = 8'h00;
	assign o_ready = pend != 8'h00 && !i_discard;
	assign o_count = pend;
	always @(posedge i_mclk) begin
		if (i_discard)
			pend <= 8'h00;
		else if (i_take && pend != 8'h00)
			pend <= pend - 8'h01;
	end
endmodule
